// ---- rtl/id_and_pin_strap_registers.sv ----
// Read-only identification and strap capture register bank.
// Assumes a serial management target decodes the host access into index and strobes,
// and that an on-chip memory loader delivers the serial byte after each reset.
`include "id_strap_cfg.svh"
module id_and_pin_strap_registers
  import id_strap_pkg::*;
#(
  parameter logic [15:0] VENDOR_IDENTIFIER  = 16'hA5C3, // Arbitrary value
  parameter logic [7:0]  PRODUCT_IDENTIFIER = 8'h5A,    // Arbitrary value
  parameter logic [7:0]  DIE_REVISION       = 8'h3C     // Arbitrary value
) (
  input  wire logic        i_sys_clk,         // 250 MHz register clock
  input  wire logic        i_rst_n,           // Async reset, active low
  input  wire strap_pins_s i_strap_pins,      // Pin levels, asynchronous
  input  wire logic        i_serial_valid,    // Serial byte from memory valid
  input  wire logic [7:0]  i_serial_data,     // Serial byte from memory
  input  wire reg_req_s    i_req,             // Read index and strobe
  input  wire logic        i_write_en,        // Host write strobe, ignored
  input  wire logic [7:0]  i_write_data,      // Host write data, ignored
  output logic      [7:0]  o_read_data,       // Registered read data
  output logic             o_read_valid       // Read data strobe
);

  // Strap pin levels, two stages deep
  strap_pins_s pins_meta, next_pins_meta;
  strap_pins_s pins_sync, next_pins_sync;

  // Next synchroniser values: the first stage feeds only the second
  always_comb begin
    next_pins_meta = i_strap_pins;
    next_pins_sync = pins_meta;
  end

  // Register the synchroniser; pins are asynchronous to the bank clock
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= next_pins_meta;
      pins_sync <= next_pins_sync;
    end
  end

  // Encode the two configuration pins as one code; an illegal level reads as zero
  function automatic logic [2:0] pin_code(
    input logic       hi,  // Two-level pin
    input pin_level_e lo   // Three-level pin
  );
    logic [2:0] base;
    base = hi ? 3'h3 : 3'h0;
    case (lo)
      LVL_LOW: begin
        pin_code = base;
      end
      LVL_MID: begin
        pin_code = base + 3'h1;
      end
      LVL_HIGH: begin
        pin_code = base + 3'h2;
      end
      default: begin
        pin_code = 3'h0;
      end
    endcase
  endfunction : pin_code

  // Build the whole strap byte from one synchronised pin sample
  function automatic logic [7:0] strap_byte(input strap_pins_s pins);
    logic [7:0] value;
    value = `STRAP_RESET;
    value[`STRAP_CTRL_BIT] = pins.control_source_pin;
    // Hard mode leaves the code field at zero
    if (!pins.control_source_pin) begin
      value[`STRAP_CODE_MSB:`STRAP_CODE_LSB] =
        pin_code(pins.high_pin, pins.low_pin);
    end
    strap_byte = value;
  endfunction : strap_byte

  // Map an index onto its register; unmapped indices read zero
  function automatic logic [7:0] read_mux(
    input logic [3:0] index,     // Register index
    input logic [7:0] serial_q,  // Current serial byte
    input logic [7:0] strap_q    // Captured strap byte
  );
    case (index)
      `IDX_VENDOR_ID_HIGH: begin
        read_mux = VENDOR_IDENTIFIER[15:8];
      end
      `IDX_VENDOR_ID_LOW: begin
        read_mux = VENDOR_IDENTIFIER[7:0];
      end
      `IDX_PRODUCT_IDENTIFIER: begin
        read_mux = PRODUCT_IDENTIFIER;
      end
      `IDX_DIE_REVISION: begin
        read_mux = DIE_REVISION;
      end
      `IDX_UNIT_SERIAL: begin
        read_mux = serial_q;
      end
      `IDX_SOFT_STRAP: begin
        read_mux = strap_q;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  endfunction : read_mux

  // Capture sequence: the synchroniser comes out of reset holding zeros,
  // so two edges pass before its second stage shows the real pins.
  // Limitation: the strap keeps the pin levels sampled at the first edge after release.
  typedef enum logic [1:0] {CAP_FILL, CAP_SETTLE, CAP_TAKE, CAP_HOLD} cap_state_e;
  cap_state_e  cap_state, next_cap_state;
  logic [7:0]  strap, next_strap;

  // Next capture state and strap; the strap moves only in the take state
  always_comb begin
    next_cap_state = cap_state;
    next_strap     = strap;
    case (cap_state)
      CAP_FILL: begin
        next_cap_state = CAP_SETTLE;
      end
      CAP_SETTLE: begin
        next_cap_state = CAP_TAKE;
      end
      CAP_TAKE: begin
        next_cap_state = CAP_HOLD;
        next_strap     = strap_byte(pins_sync);
      end
      CAP_HOLD: begin
        next_cap_state = CAP_HOLD;
      end
      default: begin
        next_cap_state = CAP_FILL;
      end
    endcase
  end

  // Register the capture state and strap byte
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap_state <= CAP_FILL;
      strap     <= `STRAP_RESET;
    end else begin
      cap_state <= next_cap_state;
      strap     <= next_strap;
    end
  end

  // Serial byte from the memory loader
  logic [7:0]  serial, next_serial;

  // Next serial byte; host writes never reach here
  always_comb begin
    next_serial = serial;
    if (i_serial_valid) begin
      next_serial = i_serial_data;
    end
  end

  // Register the serial byte; zero until the loader strobes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      serial <= `SERIAL_RESET;
    end else begin
      serial <= next_serial;
    end
  end

  // Writes are deliberately not decoded at all
  logic        unused_write;
  assign unused_write = i_write_en ^ (^i_write_data);

  // Read answer: data drops to zero between reads
  logic [7:0]  next_read_data;
  logic        next_read_valid;

  // Next read answer, one cycle after the strobe
  always_comb begin
    next_read_valid = i_req.read_en;
    next_read_data  = 8'h00;
    if (i_req.read_en) begin
      next_read_data = read_mux(i_req.index, serial, strap);
    end
  end

  // Register the read answer
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_read_data  <= 8'h00;
      o_read_valid <= 1'b0;
    end else begin
      o_read_data  <= next_read_data;
      o_read_valid <= next_read_valid;
    end
  end

endmodule : id_and_pin_strap_registers

// ---- rtl/id_strap_cfg.svh ----
// Offsets, field positions and reset values of the identification and strap registers.
// Assumes inclusion by the register bank only.
`ifndef ID_STRAP_CFG_SVH
`define ID_STRAP_CFG_SVH
`define IDX_VENDOR_ID_HIGH     4'h0
`define IDX_VENDOR_ID_LOW      4'h1
`define IDX_PRODUCT_IDENTIFIER 4'h2
`define IDX_DIE_REVISION       4'h3
`define IDX_UNIT_SERIAL        4'h4
`define IDX_SOFT_STRAP         4'h8
`define STRAP_CTRL_BIT         7
`define STRAP_CODE_MSB         6
`define STRAP_CODE_LSB         4
`define STRAP_RESET            8'h00
`define SERIAL_RESET           8'h00
`endif

// ---- rtl/id_strap_pkg.sv ----
// Types shared by the identification and strap register bank.
// Assumes id_strap_cfg.svh supplies the numeric constants.
package id_strap_pkg;
  // Three-level pin reading
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} pin_level_e;
  // Raw configuration pin sample
  typedef struct packed {
    logic       control_source_pin;
    logic       high_pin;
    pin_level_e low_pin;
  } strap_pins_s;
  // Register read port
  typedef struct packed {
    logic [3:0] index;
    logic       read_en;
  } reg_req_s;
endpackage : id_strap_pkg

// ---- verification/id_and_pin_strap_registers_assertions.sv ----
// Checker for the identification and strap register bank.
// Assumes a bind onto the bank top; sees its ports only.
module id_and_pin_strap_registers_assertions import id_strap_pkg::*; #(
  parameter logic [15:0] VENDOR_IDENTIFIER  = 16'hA5C3,
  parameter logic [7:0]  PRODUCT_IDENTIFIER = 8'h5A,
  parameter logic [7:0]  DIE_REVISION       = 8'h3C
) (
  input wire logic i_sys_clk, i_rst_n, i_serial_valid, i_write_en, o_read_valid,
  input wire strap_pins_s i_strap_pins,
  input wire reg_req_s    i_req,
  input wire logic [7:0]  i_serial_data, i_write_data, o_read_data
);
  logic [7:0] last_ser;
  // Last loader byte, so serial reads have a reference
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) last_ser <= 8'h00;
    else if (i_serial_valid) last_ser <= i_serial_data;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence rd(logic [3:0] ix);
    i_req.read_en && i_req.index == ix;
  endsequence
  a_vendor_high: assert property (
    rd(4'h0) |=> o_read_valid && o_read_data == VENDOR_IDENTIFIER[15:8]) else $error("bad vh");
  a_vendor_low: assert property (
    rd(4'h1) |=> o_read_valid && o_read_data == VENDOR_IDENTIFIER[7:0]) else $error("bad vl");
  a_product_id: assert property (
    rd(4'h2) |=> o_read_data == PRODUCT_IDENTIFIER) else $error("bad product");
  a_die_rev: assert property (
    rd(4'h3) |=> o_read_data == DIE_REVISION) else $error("bad revision");
  a_serial_load: assert property (
    rd(4'h4) && !i_serial_valid |=> o_read_data == last_ser) else $error("bad serial");
  a_strap_hold: assert property (
    rd(4'h8) ##5 rd(4'h8) |=> o_read_data == $past(o_read_data, 5)) else $error("strap moved");
  a_strap_code: assert property (
    rd(4'h8) |=> (o_read_data[7] ? o_read_data[6:4] == 3'h0 : o_read_data[6:4] <= 3'h5))
    else $error("bad code");
  a_strap_rsvd: assert property (
    rd(4'h8) |=> o_read_data[3:0] == 4'h0) else $error("bad reserved");
endmodule : id_and_pin_strap_registers_assertions

// ---- verification/id_and_pin_strap_registers_bench.sv ----
// Bench for the identification and strap register bank.
// Assumes default identity parameters and the host model.
module id_and_pin_strap_registers_bench import id_strap_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 0, i_rst_n = 0, sv = 0, we, rv;
  strap_pins_s pins = '0;
  reg_req_s req;
  logic [7:0] ser = 8'h00, wd, rdd, rd0;
  logic [7:0] exp_t [6] = '{8'hA5, 8'hC3, 8'h5A, 8'h3C, 8'h96, 8'h00};
  int fails = 0, num_checks = 0;
  initial forever #2 i_sys_clk = ~i_sys_clk;
  id_and_pin_strap_registers dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_strap_pins(pins),
    .i_serial_valid(sv), .i_serial_data(ser), .i_req(req), .i_write_en(we),
    .i_write_data(wd), .o_read_data(rdd), .o_read_valid(rv));
  mgmt_host_model host (.i_sys_clk(i_sys_clk), .o_req(req), .o_write_en(we),
    .o_write_data(wd), .i_read_valid(rv), .i_read_data(rdd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, got, exp); end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // Pins settle inside reset; strap readable three edges after release
  initial begin
    for (int c = 0; c < 7; c++) begin
      @(posedge i_sys_clk) i_rst_n <= 1'b0;
      pins <= '{control_source_pin: c == 6, high_pin: c > 2, low_pin: pin_level_e'(c % 3)};
      repeat (6) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      host.rd(4'h8, rd0);
      chk(rd0, (c == 6) ? 8'h80 : {1'b0, 3'(c), 4'h0});
      pins <= ~pins;
      host.wr(4'h8, 8'h7F);
      host.rd(4'h8, rd0);
      chk(rd0, (c == 6) ? 8'h80 : {1'b0, 3'(c), 4'h0});
    end
    $display("test straps done");
    @(posedge i_sys_clk) begin sv <= 1'b1; ser <= 8'h96; end
    @(posedge i_sys_clk) sv <= 1'b0;
    // Writes first, so a bank that took them would read back FF
    for (int i = 0; i < 6; i++) begin
      host.wr(4'(i), 8'hFF);
      host.rd(4'(i), rd0);
      chk(rd0, exp_t[i]);
    end
    $display("test identifiers done");
    tally_and_finish();
  end
  initial begin
    #5000;
    fails++;
    tally_and_finish();
  end
endmodule : id_and_pin_strap_registers_bench
bind id_and_pin_strap_registers id_and_pin_strap_registers_assertions #(
  .VENDOR_IDENTIFIER(VENDOR_IDENTIFIER), .PRODUCT_IDENTIFIER(PRODUCT_IDENTIFIER),
  .DIE_REVISION(DIE_REVISION)) chk_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_serial_valid(i_serial_valid), .i_write_en(i_write_en), .o_read_valid(o_read_valid),
  .i_strap_pins(i_strap_pins), .i_req(i_req), .i_serial_data(i_serial_data),
  .i_write_data(i_write_data), .o_read_data(o_read_data));

// ---- verification/mgmt_host_model.sv ----
// Management bus host model: single reads and writes.
// Assumes the bank answers one cycle after the taken edge.
module mgmt_host_model import id_strap_pkg::*; (
  input  wire logic       i_sys_clk,    // Bank clock
  output reg_req_s        o_req,        // Read index and strobe
  output logic            o_write_en,   // Write strobe
  output logic [7:0]      o_write_data, // Write data
  input  wire logic       i_read_valid, // Answer strobe
  input  wire logic [7:0] i_read_data   // Answer data
);
  initial begin
    o_req <= '0;
    o_write_en <= 1'b0;
    o_write_data <= 8'h00;
  end
  // Missing answer returns EE so it never matches
  task automatic rd(input logic [3:0] ix, output logic [7:0] d);
    @(posedge i_sys_clk) o_req <= '{index: ix, read_en: 1'b1};
    @(posedge i_sys_clk) o_req.read_en <= 1'b0;
    @(posedge i_sys_clk) d = (i_read_valid === 1'b1) ? i_read_data : 8'hEE;
  endtask : rd
  task automatic wr(input logic [3:0] ix, input logic [7:0] d);
    @(posedge i_sys_clk) begin o_req.index <= ix; o_write_en <= 1'b1; o_write_data <= d; end
    @(posedge i_sys_clk) o_write_en <= 1'b0;
  endtask : wr
endmodule : mgmt_host_model
